// file: logic/basic_timer.v
// Basic 16-bit up-counting timer with an APB register interface.
`include "basic_timer_regs.vh"

module basic_timer (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output reg         pslverr,
  output reg         trigger_out,
  output reg         update_dma_request,
  output reg         update_irq
);

  // --------------------------------------------------------------------------
  // Register state
  // --------------------------------------------------------------------------
  // The low control word holds the run, inhibit, source, single pulse and buffer bits.
  reg        run_enable;
  reg        update_inhibit;
  reg        update_source_select;
  reg        single_pulse;
  reg        reload_buffer_enable;
  reg [2:0]  trigger_select;
  reg        update_dma_enable;
  reg        update_irq_enable;
  reg        update_flag;
  reg [15:0] count_value;
  reg [15:0] prescale_divider;
  reg [15:0] reload_value;

  wire [15:0] prescale_active;
  wire [15:0] reload_shadow;
  wire [15:0] reload_active;
  wire        counter_tick;

  // --------------------------------------------------------------------------
  // Bus decode
  // --------------------------------------------------------------------------
  // Only the low halfword lanes carry register data; lanes 2 and 3 are dropped.
  function [15:0] lane_merge;
    input [15:0] old_value;
    input [31:0] data;
    input [3:0]  strb;
    begin
      lane_merge = {(strb[1] ? data[15:8] : old_value[15:8]),
                    (strb[0] ? data[7:0] : old_value[7:0])};
    end
  endfunction

  // Writes land at the access edge; read data is sampled in the setup cycle.
  wire access_write = psel & penable & pwrite;
  wire setup_phase  = psel & ~penable;

  wire wr_control_zero = access_write & (paddr == `OFF_CONTROL_ZERO);
  wire wr_control_one  = access_write & (paddr == `OFF_CONTROL_ONE);
  wire wr_enable       = access_write & (paddr == `OFF_DMA_IRQ_ENABLE);
  wire wr_flags        = access_write & (paddr == `OFF_IRQ_FLAGS);
  wire wr_soft_event   = access_write & (paddr == `OFF_SOFTWARE_EVENT);
  wire wr_counter      = access_write & (paddr == `OFF_COUNTER_VALUE);
  wire wr_prescaler    = access_write & (paddr == `OFF_PRESCALER_VALUE);
  wire wr_reload       = access_write & (paddr == `OFF_AUTO_RELOAD_VALUE);

  wire [15:0] control_zero_word = {8'h00, reload_buffer_enable, 3'b000, single_pulse,
                                   update_source_select, update_inhibit, run_enable};
  wire [15:0] control_one_word  = {9'h000, trigger_select, 4'h0};
  wire [15:0] enable_word       = {7'h00, update_dma_enable, 7'h00, update_irq_enable};

  // Each merged value keeps the lane of its register that the strobes leave out.
  wire [15:0] next_control_zero = lane_merge(control_zero_word, pwdata, pstrb);
  wire [15:0] next_control_one  = lane_merge(control_one_word, pwdata, pstrb);
  wire [15:0] next_enable       = lane_merge(enable_word, pwdata, pstrb);
  wire [15:0] next_counter      = lane_merge(count_value, pwdata, pstrb);
  wire [15:0] next_prescaler    = lane_merge(prescale_divider, pwdata, pstrb);
  wire [15:0] next_reload       = lane_merge(reload_value, pwdata, pstrb);

  // The generate bit never stores a value, so it always reads back as zero.
  wire software_update_generate = wr_soft_event & pstrb[0]
                                  & pwdata[`BIT_SOFTWARE_UPDATE_GEN];

  // A flag write clears only when lane 0 is written with a zero in bit 0.
  wire flag_clear = wr_flags & pstrb[0] & ~pwdata[`BIT_UPDATE_FLAG];

  // Every access completes with no wait states.
  assign pready = 1'b1;

  // --------------------------------------------------------------------------
  // Event generation
  // --------------------------------------------------------------------------
  // A software generate or a counter write in the same cycle overrides a wrap.
  wire overflow = counter_tick & (count_value == reload_active)
                  & ~software_update_generate & ~wr_counter;

  // With the inhibit bit set the counter still restarts, but nothing is loaded or flagged.
  wire update_event = (overflow | software_update_generate) & ~update_inhibit;

  wire qualified_update = ~update_inhibit
                          & (overflow | (software_update_generate
                                         & ~update_source_select));

  wire counter_start = wr_control_zero & next_control_zero[`BIT_RUN_ENABLE]
                       & ~run_enable;

  // --------------------------------------------------------------------------
  // Prescaler and shadow registers
  // --------------------------------------------------------------------------
  // The prescaler counter is cleared together with the main counter.
  // Both shadows load on one update event, so with the buffer on divider and wrap point change together.
  prescale_divider_unit u_prescale (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .run     (run_enable),
    .clear   (software_update_generate),
    .divider (prescale_active),
    .tick    (counter_tick)
  );

  shadow_load #(
    .WIDTH (16)
  ) u_prescale_shadow (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .load    (update_event),
    .preload (prescale_divider),
    .shadow  (prescale_active)
  );

  shadow_load #(
    .WIDTH (16)
  ) u_reload_shadow (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .load    (update_event),
    .preload (reload_value),
    .shadow  (reload_shadow)
  );

  // With the buffer off a reload write acts at once, even in mid period.
  assign reload_active = reload_buffer_enable ? reload_shadow : reload_value;

  // --------------------------------------------------------------------------
  // Control registers
  // --------------------------------------------------------------------------
  // Single pulse mode drops run enable on the update that ends the pulse,
  // unless the same cycle writes this register.
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      run_enable           <= `RST_BIT;
      update_inhibit       <= `RST_BIT;
      update_source_select <= `RST_BIT;
      single_pulse         <= `RST_BIT;
      reload_buffer_enable <= `RST_BIT;
    end
    else if (wr_control_zero)
    begin
      run_enable           <= next_control_zero[`BIT_RUN_ENABLE];
      update_inhibit       <= next_control_zero[`BIT_UPDATE_INHIBIT];
      update_source_select <= next_control_zero[`BIT_UPDATE_SOURCE_SELECT];
      single_pulse         <= next_control_zero[`BIT_SINGLE_PULSE];
      reload_buffer_enable <= next_control_zero[`BIT_RELOAD_BUFFER_ENABLE];
    end
    else if (single_pulse & update_event)
      run_enable <= 1'b0;
  end

  // The enable bits act from the cycle after the write.
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      trigger_select    <= `RST_SELECT;
      update_dma_enable <= `RST_BIT;
      update_irq_enable <= `RST_BIT;
    end
    else
    begin
      if (wr_control_one)
        trigger_select <= next_control_one[`MSB_TRIGGER_SELECT:`LSB_TRIGGER_SELECT];
      if (wr_enable)
      begin
        update_dma_enable <= next_enable[`BIT_UPDATE_DMA_ENABLE];
        update_irq_enable <= next_enable[`BIT_UPDATE_IRQ_ENABLE];
      end
    end
  end

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      prescale_divider <= `RST_HALF;
      reload_value     <= `RST_HALF;
    end
    else
    begin
      if (wr_prescaler)
        prescale_divider <= next_prescaler;
      if (wr_reload)
        reload_value <= next_reload;
    end
  end

  // --------------------------------------------------------------------------
  // Update flag
  // --------------------------------------------------------------------------
  // The flag records only the updates that the source select lets through.
  // A new event in the clearing cycle keeps the flag set.
  always @(posedge ref_clk)
  begin
    if (!nrst)
      update_flag <= `RST_BIT;
    else if (qualified_update)
      update_flag <= 1'b1;
    else if (flag_clear)
      update_flag <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // A software generate outranks a bus write, which outranks counting.
  always @(posedge ref_clk)
  begin
    if (!nrst)
      count_value <= `RST_HALF;
    else if (software_update_generate)
      count_value <= 16'h0000;
    else if (wr_counter)
      count_value <= next_counter;
    else if (overflow)
      count_value <= 16'h0000;
    else if (counter_tick)
      count_value <= count_value + 16'h0001;
  end

  // --------------------------------------------------------------------------
  // Trigger, DMA and interrupt outputs
  // --------------------------------------------------------------------------
  // The trigger source is picked here so that the pulse leaves a flop a cycle later.
  reg next_trigger;

  always @*
  begin
    next_trigger = 1'b0;
    case (trigger_select)
      `TRIG_ON_RESET:  next_trigger = software_update_generate;
      `TRIG_ON_START:  next_trigger = counter_start;
      `TRIG_ON_UPDATE: next_trigger = update_event;
      default:         next_trigger = 1'b0;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!nrst)
      trigger_out <= 1'b0;
    else
      trigger_out <= next_trigger;
  end

  // The interrupt follows the flag value that the current cycle will leave behind.
  wire next_update_flag = qualified_update | (update_flag & ~flag_clear);

  // Each qualifying update yields a one-cycle DMA request.
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      update_dma_request <= 1'b0;
      update_irq         <= 1'b0;
    end
    else
    begin
      update_dma_request <= qualified_update & update_dma_enable;
      update_irq         <= next_update_flag & update_irq_enable;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Read data is captured in the setup cycle and presented in the access cycle.
  // A write cycle captures zero so that no stale read value lingers.
  reg [31:0] next_prdata;
  reg        next_pslverr;

  always @*
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      `OFF_CONTROL_ZERO:      next_prdata = {16'h0000, control_zero_word};
      `OFF_CONTROL_ONE:       next_prdata = {16'h0000, control_one_word};
      `OFF_DMA_IRQ_ENABLE:    next_prdata = {16'h0000, enable_word};
      `OFF_IRQ_FLAGS:         next_prdata = {31'h0000_0000, update_flag};
      `OFF_SOFTWARE_EVENT:    next_prdata = 32'h0000_0000;
      `OFF_COUNTER_VALUE:     next_prdata = {16'h0000, count_value};
      `OFF_PRESCALER_VALUE:   next_prdata = {16'h0000, prescale_divider};
      `OFF_AUTO_RELOAD_VALUE: next_prdata = {16'h0000, reload_value};
      default:                next_pslverr = 1'b1;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (setup_phase)
    begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

endmodule

// file: include/basic_timer_regs.vh
// Register offsets, field positions and reset values of the basic up-counting timer.
`ifndef BASIC_TIMER_REGS_VH
`define BASIC_TIMER_REGS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFF_CONTROL_ZERO      12'h000
`define OFF_CONTROL_ONE       12'h004
`define OFF_DMA_IRQ_ENABLE    12'h00c
`define OFF_IRQ_FLAGS         12'h010
`define OFF_SOFTWARE_EVENT    12'h014
`define OFF_COUNTER_VALUE     12'h024
`define OFF_PRESCALER_VALUE   12'h028
`define OFF_AUTO_RELOAD_VALUE 12'h02c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_RUN_ENABLE            0
`define BIT_UPDATE_INHIBIT        1
`define BIT_UPDATE_SOURCE_SELECT  2
`define BIT_SINGLE_PULSE          3
`define BIT_RELOAD_BUFFER_ENABLE  7
`define MSB_TRIGGER_SELECT        6
`define LSB_TRIGGER_SELECT        4
`define BIT_UPDATE_DMA_ENABLE     8
`define BIT_UPDATE_IRQ_ENABLE     0
`define BIT_UPDATE_FLAG           0
`define BIT_SOFTWARE_UPDATE_GEN   0

// ----------------------------------------------------------------------------
// Trigger output selections
// ----------------------------------------------------------------------------
`define TRIG_ON_RESET   3'b000
`define TRIG_ON_START   3'b001
`define TRIG_ON_UPDATE  3'b010

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_HALF        16'h0000
`define RST_BIT         1'b0
`define RST_SELECT      3'b000

`endif

// file: logic/shadow_load.v
// Shadow copy of a preload register, refreshed only on an update event.
module shadow_load #(
  parameter WIDTH = 16
) (
  input  wire             ref_clk,
  input  wire             nrst,
  input  wire             load,
  input  wire [WIDTH-1:0] preload,
  output reg  [WIDTH-1:0] shadow
);

  always @(posedge ref_clk)
  begin
    if (!nrst)
      shadow <= {WIDTH{1'b0}};
    else if (load)
      shadow <= preload;
  end

endmodule

// file: logic/prescale_divider_unit.v
// Prescaler counter that yields one counter tick every divider plus one clocks.
`include "basic_timer_regs.vh"

module prescale_divider_unit (
  input  wire        ref_clk,
  input  wire        nrst,
  input  wire        run,
  input  wire        clear,
  input  wire [15:0] divider,
  output wire        tick
);

  reg [15:0] prescale_count;

  assign tick = run & (prescale_count == divider);

  always @(posedge ref_clk)
  begin
    if (!nrst)
      prescale_count <= `RST_HALF;
    else if (clear)
      prescale_count <= 16'h0000;
    else if (tick)
      prescale_count <= 16'h0000;
    else if (run)
      prescale_count <= prescale_count + 16'h0001;
  end

endmodule

// file: dv/basic_timer_monitor.sv
// Port checker of the basic up-counting timer.
module basic_timer_monitor (
  input logic        ref_clk,
  input logic        nrst,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0]  pstrb,
  input logic        pready,
  input logic [31:0] prdata,
  input logic        pslverr,
  input logic        trigger_out,
  input logic        update_dma_request,
  input logic        update_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       run_h;
  logic       dma_h;
  logic       irq_h;
  logic [2:0] sel_h;
  wire        wr = psel && penable && pwrite;
  wire        acc = psel && penable;
  wire        mapped = paddr inside {12'h000, 12'h004, 12'h00c, 12'h010,
                                     12'h014, 12'h024, 12'h028, 12'h02c};

  // --------------------------------------------------------------------------
  // Copies of the control fields, kept from the bus writes.
  // --------------------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      run_h <= 1'b0;
      dma_h <= 1'b0;
      irq_h <= 1'b0;
      sel_h <= 3'h0;
    end
    else if (wr)
    begin
      if (paddr == 12'h000 && pstrb[0])
        run_h <= pwdata[0];
      if (paddr == 12'h004 && pstrb[0])
        sel_h <= pwdata[6:4];
      if (paddr == 12'h00c && pstrb[0])
        irq_h <= pwdata[0];
      if (paddr == 12'h00c && pstrb[1])
        dma_h <= pwdata[8];
    end
  end

  // --------------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_rst_zero;
    $rose(nrst) |-> !trigger_out && !update_dma_request && !update_irq && prdata == 32'h0;
  endproperty
  a_rst_zero: assert property (p_rst_zero)
    else $error("outputs not clear after reset");
  property p_upper;
    acc && !pwrite |-> prdata[31:16] == 16'h0;
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper read half not zero");
  property p_unmap;
    acc && !mapped |-> pslverr;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access without error");
  property p_map;
    acc && mapped |-> !pslverr;
  endproperty
  a_map: assert property (p_map)
    else $error("mapped access flagged as error");
  property p_sw_trig;
    wr && pstrb[0] && paddr == 12'h014 && pwdata[0] && sel_h == 3'b000 |-> ##[1:2] trigger_out;
  endproperty
  a_sw_trig: assert property (p_sw_trig)
    else $error("no trigger on counter reset");
  property p_start;
    wr && pstrb[0] && paddr == 12'h000 && pwdata[0] && !run_h && sel_h == 3'b001
      |-> ##[1:2] trigger_out;
  endproperty
  a_start: assert property (p_start)
    else $error("no trigger on counter start");
  property p_dma_off;
    !dma_h [*3] |-> !update_dma_request;
  endproperty
  a_dma_off: assert property (p_dma_off)
    else $error("dma request while disabled");
  property p_irq_off;
    !irq_h [*3] |-> !update_irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt while disabled");

  c_dma: cover property (update_dma_request);
  c_trig: cover property (trigger_out);
  c_err: cover property (acc && !mapped);
endmodule

bind basic_timer basic_timer_monitor mon (
  .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .trigger_out(trigger_out),
  .update_dma_request(update_dma_request), .update_irq(update_irq)
);

// file: dv/tb_basic_timer.sv
// Self-checking testbench of the basic up-counting timer.
module tb_basic_timer;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk, nrst, psel, penable, pwrite, err;
  logic        pready, pslverr, trigger_out, update_dma_request, update_irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, dd, t0, d0, v;
  logic [3:0]  pstrb;
  int          fail_count = 0, checks = 0, trig_n = 0, dma_n = 0, n;
  logic [11:0] regs[8] = '{12'h000, 12'h004, 12'h00c, 12'h010,
                           12'h014, 12'h024, 12'h028, 12'h02c};

  basic_timer dut (
    .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .trigger_out(trigger_out),
    .update_dma_request(update_dma_request), .update_irq(update_irq)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    trig_n <= trig_n + (trigger_out === 1'b1);
    dma_n <= dma_n + (update_dma_request === 1'b1);
  end

  // --------------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------------
  task automatic give_verdict;
    $display("counts: checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Expected trigger pulses for one generate or one start in a select mode.
  function automatic logic [31:0] exp_trig(input int sel, input logic start,
                                           input logic inhib);
    if (start)
      return {31'h0, sel == 1};
    return {31'h0, sel == 0 || (sel == 2 && !inhib)};
  endfunction

  // Clocks from one wrap to the next with an undivided counter clock.
  function automatic logic [31:0] wrap_period(input logic [31:0] reload);
    return reload + 32'd1;
  endfunction

  // Read-back value of a halfword register after a word write.
  function automatic logic [31:0] half(input logic [31:0] w);
    return {16'h0, w[15:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && k < 20)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 20)
    begin
      fail_count++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d, 4'b1111);
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0, 4'h0);
    chk(rd, exp, "register read");
    chk({31'h0, err}, 32'h0, "read error");
  endtask

  // Counter advance across k plus three clocks, taken from two reads.
  task automatic delta(input int k);
    apb(12'h024, 1'b0, 32'h0, 4'h0);
    v = rd;
    repeat (k) @(posedge ref_clk);
    apb(12'h024, 1'b0, 32'h0, 4'h0);
    dd = (rd - v) & 32'hffff;
  endtask

  task automatic wait_trig;
    n = 0;
    @(posedge ref_clk);
    while (trigger_out !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 200)
    begin
      fail_count++;
      give_verdict();
    end
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    {nrst, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    void'($urandom(32'hba49234a));
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 32'h0);
    apb(12'h026, 1'b0, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    $display("test reset and map done");
    v = $urandom;
    wr(12'h028, v);
    rdchk(12'h028, half(v));
    v = $urandom;
    apb(12'h02c, 1'b1, v, 4'b0011);
    rdchk(12'h02c, half(v));
    wr(12'h028, 32'h0);
    wr(12'h02c, 32'hffff);
    wr(12'h014, 32'h1);
    v = $urandom & 32'h0fff;
    wr(12'h024, v);
    rdchk(12'h024, v);
    wr(12'h000, 32'h1);
    delta(0);
    chk(dd, 32'd3, "advance undivided");
    wr(12'h028, 32'h3);
    delta(9);
    chk(dd, 32'd12, "divider before update");
    wr(12'h014, 32'h1);
    delta(9);
    chk(dd, 32'd3, "divider after update");
    wr(12'h000, 32'h0);
    delta(0);
    chk(dd, 32'd0, "stopped counter");
    wr(12'h024, 32'd100);
    wr(12'h014, 32'h1);
    rdchk(12'h024, 32'h0);
    rdchk(12'h014, 32'h0);
    wr(12'h028, 32'h0);
    $display("test counting done");
    for (int s = 0; s < 3; s++)
    begin
      wr(12'h000, 32'h0);
      wr(12'h004, s << 4);
      t0 = trig_n;
      wr(12'h014, 32'h1);
      repeat (5) @(posedge ref_clk);
      chk(trig_n - t0, exp_trig(s, 1'b0, 1'b0), "trigger on generate");
      t0 = trig_n;
      wr(12'h000, 32'h1);
      repeat (5) @(posedge ref_clk);
      chk(trig_n - t0, exp_trig(s, 1'b1, 1'b0), "trigger on start");
    end
    $display("test trigger modes done");
    wr(12'h000, 32'h0);
    v = 3 + $urandom % 14;
    wr(12'h02c, v);
    wr(12'h00c, 32'h0101);
    wr(12'h014, 32'h1);
    wr(12'h010, 32'h0);
    rdchk(12'h010, 32'h0);
    wr(12'h000, 32'h1);
    wait_trig();
    wait_trig();
    chk(n + 1, wrap_period(v), "overflow period");
    chk(update_dma_request, 1'b1, "dma on overflow");
    chk(update_irq, 1'b1, "interrupt level");
    wr(12'h010, 32'h1);
    rdchk(12'h010, 32'h1);
    wr(12'h00c, 32'h0100);
    repeat (2) @(posedge ref_clk);
    chk(update_irq, 1'b0, "interrupt masked");
    wr(12'h00c, 32'h0);
    d0 = dma_n;
    repeat (40) @(posedge ref_clk);
    chk(dma_n - d0, 32'h0, "dma disabled");
    wr(12'h000, 32'h0);
    wr(12'h00c, 32'h0101);
    wr(12'h010, 32'h0);
    rdchk(12'h010, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk(update_irq, 1'b0, "interrupt cleared");
    $display("test overflow done");
    for (int i = 0; i < 3; i++)
    begin
      wr(12'h000, i == 0 ? 32'h2 : (i == 1 ? 32'h4 : 32'h0));
      wr(12'h010, 32'h0);
      wr(12'h024, 32'd50);
      t0 = trig_n;
      d0 = dma_n;
      wr(12'h014, 32'h1);
      repeat (5) @(posedge ref_clk);
      chk(trig_n - t0, exp_trig(2, 1'b0, i == 0), "update trigger");
      chk(dma_n - d0, i == 2, "update dma");
      rdchk(12'h010, i == 2);
      rdchk(12'h024, 32'h0);
    end
    $display("test inhibit and source done");
    wr(12'h02c, 32'd5);
    wr(12'h014, 32'h1);
    wr(12'h000, 32'h80);
    wr(12'h02c, 32'd20);
    wr(12'h000, 32'h81);
    wait_trig();
    chk(n, wrap_period(5), "buffered reload before update");
    wait_trig();
    chk(n + 1, wrap_period(20), "buffered reload after update");
    wr(12'h000, 32'h0);
    wr(12'h024, 32'h0);
    wr(12'h02c, 32'd9);
    wr(12'h000, 32'h9);
    wait_trig();
    chk(n, wrap_period(9), "unbuffered reload");
    delta(0);
    chk(dd, 32'd0, "single pulse stop");
    rdchk(12'h024, 32'h0);
    $display("test reload buffer and single pulse done");
    give_verdict();
  end
endmodule
